// ===== inc/scx_pkg.sv
// constants and types of the serial controller with extended modes
`default_nettype none
package scx_pkg;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          FIFO_DEPTH = 8;
  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_DIV   = 8'h04;
  localparam logic [7:0]  ADDR_RX0   = 8'h10;
  localparam logic [7:0]  ADDR_RX1   = 8'h14;
  localparam logic [7:0]  ADDR_TX0   = 8'h20;
  localparam logic [7:0]  ADDR_TX1   = 8'h24;
  localparam logic [7:0]  ADDR_PAT   = 8'h34;
  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0500_0004;
  localparam logic [31:0] DIV_RST    = 32'h0000_0000;
  localparam logic [31:0] PAT_RST    = 32'h007f_ff87;
  // software-writable control bits, flag and reserved bits excluded
  localparam logic [31:0] CTRL_WMASK = 32'h00de_ffff;
  // control field positions
  localparam int          B_GO       = 0;
  localparam int          B_LEN      = 3;
  localparam int          B_NUM      = 8;
  localparam int          B_CLKP     = 11;
  localparam int          B_SP       = 12;
  localparam int          B_IF       = 16;
  localparam int          B_SLAVE    = 18;
  localparam int          B_REORD    = 19;
  localparam int          B_DUAL     = 22;
  localparam int          B_VAR      = 23;
  // reorder field encodings
  localparam logic [1:0]  RO_NONE    = 2'h0;
  localparam logic [1:0]  RO_BOTH    = 2'h1;
  localparam logic [1:0]  RO_ONLY    = 2'h2;
  localparam logic [1:0]  RO_SUSP    = 2'h3;
  // suspend gap adds this many serial clock periods
  localparam logic [4:0]  GAP_EXTRA  = 5'h02;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} scx_state_t;
endpackage : scx_pkg
`default_nettype wire

// ===== hw/scx_ctrl.sv
// serial controller with extended modes, its transmit fifo and bus slave
`default_nettype none

module scx_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_reg != (AW+1)'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= AW'(wp_reg + 1'b1);
      end
      if (pop) begin
        rp_reg <= AW'(rp_reg + 1'b1);
      end
      cnt_reg <= (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
    end
  end
endmodule : scx_fifo

// Behaviour
// - variable clock ignored in slave mode
// - variable clock uses pattern, both divisors
// - dual bit mode moves two lanes
// - reorder 00: no reorder, no byte gap
// - reorder 01: reorder plus byte gap
// - reorder 10: reorder, no byte gap
// - reorder 11: byte gap, original order
// - reorder only for 16, 24, 32 bits
// - word gap is interval plus two periods
// - done flag set by hardware, write-one-clear
module scx_ctrl (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [scx_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [scx_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        serial_clock_pin_i,
  output logic                             serial_clock_pin_o,
  output logic                             serial_clock_pin_oe,
  input  wire logic                        sel_n_i,
  output logic                             sel_n_o,
  output logic                             sel_n_oe,
  input  wire logic                        din0_i,
  input  wire logic                        din1_i,
  output logic                             dout0_o,
  output logic                             dout0_oe,
  output logic                             dout1_o,
  output logic                             dout1_oe
);
  logic [31:0] serial_control_status_reg, div_reg, tx1_reg, pat_reg, rx0_reg, rx1_reg;
  logic [31:0] sh0_reg, sh1_reg, rx_word, tx_word, len_mask, bmask, rd_mux;
  logic [7:0]  waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_full_reg, w_full_reg, do_wr, wr_hit, rd_hit;
  logic        go, slave, dual, var_en, clkp, len_ok, reord_en, byte_sus;
  logic [1:0]  reord, words_reg, smp_reg;
  logic [3:0]  sp;
  logic [5:0]  len, bit_reg, bits_next, gap_reg;
  logic [4:0]  edge_reg;
  logic [15:0] cnt_reg, half_val;
  logic [3:0]  sy1_reg, sy2_reg, sy3_reg, flt_reg;
  logic        clk_d_reg, ph_reg, nxt_word_reg, run, tick, lead_s, trail_s;
  logic        ev_lead, ev_trail, word_end, byte_end, done, load;
  logic        fifo_in_ready, fifo_valid;
  logic [31:0] fifo_data;
  scx_pkg::scx_state_t state_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [31:0] byte_swap(input logic [31:0] w, input logic [5:0] n);
    case (n)
      6'h10:   byte_swap = {16'h0000, w[7:0], w[15:8]};
      6'h18:   byte_swap = {8'h00, w[7:0], w[15:8], w[23:16]};
      default: byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endcase
  endfunction : byte_swap

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  assign go       = serial_control_status_reg[scx_pkg::B_GO];
  assign slave    = serial_control_status_reg[scx_pkg::B_SLAVE];
  assign dual     = serial_control_status_reg[scx_pkg::B_DUAL];
  assign var_en   = serial_control_status_reg[scx_pkg::B_VAR];
  assign clkp     = serial_control_status_reg[scx_pkg::B_CLKP];
  assign reord    = serial_control_status_reg[scx_pkg::B_REORD +: 2];
  assign sp       = serial_control_status_reg[scx_pkg::B_SP +: 4];
  assign len      = (serial_control_status_reg[scx_pkg::B_LEN +: 5] == 5'h00) ? 6'h20
                  : {1'b0, serial_control_status_reg[scx_pkg::B_LEN +: 5]};
  assign len_ok   = (len == 6'h10) || (len == 6'h18) || (len == 6'h20);
  assign reord_en = ((reord == scx_pkg::RO_BOTH) || (reord == scx_pkg::RO_ONLY))
                  && len_ok;
  assign byte_sus = (reord == scx_pkg::RO_BOTH) || (reord == scx_pkg::RO_SUSP);
  assign len_mask = (len == 6'h20) ? 32'hffff_ffff : ((32'h0000_0001 << len) - 32'h1);

  // ----------------------------------------------------------------
  // pin synchronisers, change accepted once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_reg   <= 4'h0;
      sy2_reg   <= 4'h0;
      sy3_reg   <= 4'h0;
      flt_reg   <= 4'h2;
      clk_d_reg <= 1'b0;
    end else begin
      sy1_reg   <= {din1_i, din0_i, sel_n_i, serial_clock_pin_i};
      sy2_reg   <= sy1_reg;
      sy3_reg   <= sy2_reg;
      flt_reg   <= (~(sy2_reg ^ sy3_reg) & sy3_reg) | ((sy2_reg ^ sy3_reg) & flt_reg);
      clk_d_reg <= flt_reg[0];
    end
  end

  assign lead_s  = slave && !flt_reg[1] && (flt_reg[0] != clk_d_reg) && (flt_reg[0] != clkp);
  assign trail_s = slave && !flt_reg[1] && (flt_reg[0] != clk_d_reg) && (flt_reg[0] == clkp);

  // ----------------------------------------------------------------
  // master clock generation
  // ----------------------------------------------------------------
  assign run      = !slave && (state_reg != scx_pkg::ST_IDLE);
  assign tick     = run && (cnt_reg == 16'h0000);
  assign half_val = (var_en && !slave && pat_reg[edge_reg]) ? div_reg[31:16]
                  : div_reg[15:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
    end else if (!run || tick) begin
      cnt_reg <= half_val;
    end else begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      edge_reg <= 5'h00;
    end else if (tick && (state_reg == scx_pkg::ST_SHIFT)) begin
      edge_reg <= edge_reg + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (state_reg != scx_pkg::ST_SHIFT) || slave) begin
      ph_reg <= 1'b0;
    end else if (tick) begin
      ph_reg <= !ph_reg;
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  assign ev_lead   = slave ? lead_s : (tick && (state_reg == scx_pkg::ST_SHIFT) && !ph_reg);
  assign ev_trail  = slave ? trail_s : (tick && (state_reg == scx_pkg::ST_SHIFT) && ph_reg);
  assign bits_next = bit_reg + 6'h01;
  assign word_end  = (state_reg == scx_pkg::ST_SHIFT) && ev_trail && (bits_next == len);
  assign byte_end  = (state_reg == scx_pkg::ST_SHIFT) && ev_trail && !word_end
                   && (bits_next[2:0] == 3'h0);
  assign done      = word_end && (words_reg == 2'h0);
  assign load      = ((state_reg == scx_pkg::ST_IDLE) && go)
                   || ((state_reg == scx_pkg::ST_GAP) && tick && (gap_reg == 6'h01) && nxt_word_reg)
                   || (slave && word_end && (words_reg != 2'h0));
  assign tx_word   = reord_en ? byte_swap(fifo_data, len) : fifo_data;
  assign rx_word   = {sh0_reg[30:0], smp_reg[0]} & len_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn || !go) begin
      state_reg    <= scx_pkg::ST_IDLE;
      nxt_word_reg <= 1'b0;
      gap_reg      <= 6'h00;
    end else if (load) begin
      state_reg <= scx_pkg::ST_SHIFT;
    end else if (done) begin
      state_reg <= scx_pkg::ST_IDLE;
    end else if (!slave && (word_end || (byte_end && byte_sus))) begin
      state_reg    <= scx_pkg::ST_GAP;
      nxt_word_reg <= word_end;
      // last gap tick doubles as the idle half period before the lead edge
      gap_reg      <= 6'(({1'b0, 5'(sp) + scx_pkg::GAP_EXTRA} << 1) - 6'h01);
    end else if ((state_reg == scx_pkg::ST_GAP) && tick) begin
      gap_reg <= gap_reg - 6'h01;
      if (gap_reg == 6'h01) begin
        state_reg <= scx_pkg::ST_SHIFT;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh0_reg   <= 32'h0000_0000;
      sh1_reg   <= 32'h0000_0000;
      bit_reg   <= 6'h00;
      words_reg <= 2'h0;
      smp_reg   <= 2'h0;
    end else if (load) begin
      sh0_reg <= (fifo_valid ? tx_word : 32'h0000_0000) << (6'h20 - len);
      sh1_reg <= tx1_reg << (6'h20 - len);
      bit_reg <= 6'h00;
      if (state_reg == scx_pkg::ST_IDLE) begin
        words_reg <= serial_control_status_reg[scx_pkg::B_NUM +: 2];
      end else begin
        words_reg <= words_reg - 2'h1;
      end
    end else begin
      if (ev_lead) begin
        smp_reg <= {flt_reg[3], flt_reg[2]};
      end
      if (ev_trail) begin
        sh0_reg <= {sh0_reg[30:0], smp_reg[0]};
        sh1_reg <= {sh1_reg[30:0], smp_reg[1]};
        bit_reg <= word_end ? 6'h00 : bits_next;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx0_reg <= 32'h0000_0000;
      rx1_reg <= 32'h0000_0000;
    end else if (word_end) begin
      rx0_reg <= reord_en ? byte_swap(rx_word, len) : rx_word;
      if (dual) begin
        rx1_reg <= {sh1_reg[30:0], smp_reg[1]} & len_mask;
      end
    end
  end

  assign serial_clock_pin_o  = clkp ^ ph_reg;
  assign serial_clock_pin_oe = !slave;
  assign sel_n_o             = !run;
  assign sel_n_oe            = !slave;
  assign dout0_o             = sh0_reg[31];
  assign dout0_oe            = (state_reg != scx_pkg::ST_IDLE) && (!slave || !flt_reg[1]);
  assign dout1_o             = sh1_reg[31];
  assign dout1_oe            = dout0_oe && dual;

  scx_fifo #(
    .W (scx_pkg::DATA_W),
    .D (scx_pkg::FIFO_DEPTH)
  ) u_txq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (wdata_reg & bmask),
    .in_valid  (do_wr && (waddr_reg == scx_pkg::ADDR_TX0)),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (load)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  assign bmask  = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_hit = (waddr_reg == scx_pkg::ADDR_CTRL) || (waddr_reg == scx_pkg::ADDR_DIV)
               || (waddr_reg == scx_pkg::ADDR_TX0) || (waddr_reg == scx_pkg::ADDR_TX1)
               || (waddr_reg == scx_pkg::ADDR_PAT);
  assign do_wr  = aw_full_reg && w_full_reg && !s_axi_bvalid
               && !((waddr_reg == scx_pkg::ADDR_TX0) && !fifo_in_ready);
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= scx_pkg::RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? scx_pkg::RESP_OK : scx_pkg::RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_control_status_reg <= scx_pkg::CTRL_RST;
    end else begin
      if (do_wr && (waddr_reg == scx_pkg::ADDR_CTRL)) begin
        serial_control_status_reg <=
          ((serial_control_status_reg & ~(scx_pkg::CTRL_WMASK & bmask))
          | (wdata_reg & scx_pkg::CTRL_WMASK & bmask))
          & ~(wdata_reg & bmask & (32'h1 << scx_pkg::B_IF));
      end
      if (done) begin
        serial_control_status_reg[scx_pkg::B_IF] <= 1'b1;
        serial_control_status_reg[scx_pkg::B_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= scx_pkg::DIV_RST;
      tx1_reg <= 32'h0000_0000;
      pat_reg <= scx_pkg::PAT_RST;
    end else if (do_wr) begin
      case (waddr_reg)
        scx_pkg::ADDR_DIV: div_reg <= (div_reg & ~bmask) | (wdata_reg & bmask);
        scx_pkg::ADDR_TX1: tx1_reg <= (tx1_reg & ~bmask) | (wdata_reg & bmask);
        scx_pkg::ADDR_PAT: pat_reg <= (pat_reg & ~bmask) | (wdata_reg & bmask);
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      scx_pkg::ADDR_CTRL: rd_mux = serial_control_status_reg;
      scx_pkg::ADDR_DIV:  rd_mux = div_reg;
      scx_pkg::ADDR_RX0:  rd_mux = rx0_reg;
      scx_pkg::ADDR_RX1:  rd_mux = rx1_reg;
      scx_pkg::ADDR_PAT:  rd_mux = pat_reg;
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= scx_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? scx_pkg::RESP_OK : scx_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_slave_fixed_div: assert property (slave |-> half_val == div_reg[15:0])
    else $error("slave mode used variable divisor");
  chk_fixed_reload: assert property (tick && !var_en |=> cnt_reg == $past(div_reg[15:0]))
    else $error("fixed clock reload wrong");
  chk_dual_shift: assert property (ev_trail && !load && dual |=>
      sh1_reg[31] == $past(sh1_reg[30]))
    else $error("second lane did not shift");
  chk_no_byte_gap: assert property ($rose(state_reg == scx_pkg::ST_GAP) && !byte_sus
      |-> nxt_word_reg)
    else $error("byte gap without suspend mode");
  chk_gap_length: assert property ($rose(state_reg == scx_pkg::ST_GAP) |->
      gap_reg == 6'({sp, 1'b0}) + 6'h03)
    else $error("suspend gap length wrong");
  chk_reorder_len: assert property (reord_en |-> len_ok)
    else $error("reorder on unsupported length");
  chk_flag_set: assert property (done |=> serial_control_status_reg[scx_pkg::B_IF]
      && !go)
    else $error("done did not set flag");
  chk_flag_hold: assert property (serial_control_status_reg[scx_pkg::B_IF]
      && !(do_wr && (waddr_reg == scx_pkg::ADDR_CTRL)) |=>
      serial_control_status_reg[scx_pkg::B_IF])
    else $error("flag lost without write");
  chk_idle_no_go: assert property (!go |=> state_reg == scx_pkg::ST_IDLE)
    else $error("engine busy after start cleared");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  cov_master_done: cover property (!slave && done);
  cov_byte_gap: cover property (byte_end && byte_sus ##1 state_reg == scx_pkg::ST_GAP);
  cov_dual_done: cover property (dual && done);
  cov_fifo_full: cover property (!fifo_in_ready);
endmodule : scx_ctrl
`default_nettype wire

// ===== bench/scx_slave_model.sv
// behavioural off-chip serial slave facing the controller in master mode
`default_nettype none
module scx_slave_model (
  input  wire logic        aclk,
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi0,
  input  wire logic        mosi1,
  input  wire logic [31:0] load0,
  input  wire logic [31:0] load1,
  output logic             miso0,
  output logic             miso1,
  output logic [31:0]      got0,
  output logic [31:0]      got1,
  output int               maxi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sck_q = 1'b0;
  logic        sel_q = 1'b1;
  logic        l0    = 1'b0;
  logic        l1    = 1'b0;
  logic [31:0] q0, q1;
  int          cnt;
  // ----------------------------------------
  // shift on clock edges, measure rise spacing
  // ----------------------------------------
  always @(posedge aclk) begin
    sck_q <= sclk;
    sel_q <= sel_n;
    if (sel_q && !sel_n) begin
      q0   <= load0;
      q1   <= load1;
      maxi <= 0;
      cnt  <= -1000000;
    end else if (!sel_n) begin
      cnt <= cnt + 1;
      l0  <= q0[31];
      l1  <= q1[31];
      if (sclk && !sck_q) begin
        got0 <= {got0[30:0], mosi0};
        got1 <= {got1[30:0], mosi1};
        cnt  <= 1;
        if (cnt > maxi) maxi <= cnt;
      end
      if (!sclk && sck_q) begin
        q0 <= q0 << 1;
        q1 <= q1 << 1;
      end
    end
  end
  // released lines show the inverse of their last bit
  // first bit at select fall, next bit right at the clock fall
  assign miso0 = sel_n ? ~l0 : sel_q ? load0[31] : (!sclk && sck_q) ? q0[30] : q0[31];
  assign miso1 = sel_n ? ~l1 : sel_q ? load1[31] : (!sclk && sck_q) ? q1[30] : q1[31];
endmodule : scx_slave_model
`default_nettype wire

// ===== bench/tb_scx_ctrl.sv
// testbench of the serial controller with extended modes
`default_nettype none
module tb_scx_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, load0 = 32'h0, load1 = 32'h0, got0, got1, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        serial_clock_pin_i = 1'b0, sel_n_i = 1'b1, din0_i, din1_i;
  logic        serial_clock_pin_o, serial_clock_pin_oe, sel_n_o, sel_n_oe;
  logic        dout0_o, dout0_oe, dout1_o, dout1_oe;
  int          maxi, i, error_cnt = 0, total_checks = 0;

  scx_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe, .sel_n_i,
    .sel_n_o, .sel_n_oe, .din0_i, .din1_i, .dout0_o, .dout0_oe, .dout1_o, .dout1_oe);
  scx_slave_model u_slv (.aclk, .sclk(serial_clock_pin_o), .sel_n(sel_n_o), .mosi0(dout0_o),
    .mosi1(dout1_o), .load0, .load1, .miso0(din0_i), .miso1(din1_i), .got0, .got1, .maxi);

  initial begin
    forever #50 aclk = ~aclk;
  end
  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang();
    error_cnt++;
    report_and_stop();
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 500) hang();
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 500; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 500) hang();
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic run(input logic [31:0] c);
    int n;
    wr(scx_pkg::ADDR_CTRL, c | 32'h0001_0000, scx_pkg::RESP_OK);
    wr(scx_pkg::ADDR_CTRL, c | 32'h1, scx_pkg::RESP_OK);
    for (n = 0; n < 3000; n++) begin
      rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
      if (d[0] === 1'b0) break;
    end
    if (n == 3000) hang();
  endtask : run
  task automatic xfer(input logic [31:0] c, tx, ld, ew, er, m);
    load0 <= ld;
    wr(scx_pkg::ADDR_TX0, tx, scx_pkg::RESP_OK);
    run(c);
    chk("done", {31'h0, d[16]}, 32'h1);
    chk("wire", got0 & m, ew);
    rd(scx_pkg::ADDR_RX0, scx_pkg::RESP_OK);
    chk("rx0", d & m, er);
  endtask : xfer
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
    chk("ctrl", d, scx_pkg::CTRL_RST);
    rd(scx_pkg::ADDR_PAT, scx_pkg::RESP_OK);
    chk("pattern", d, scx_pkg::PAT_RST);
    rd(scx_pkg::ADDR_DIV, scx_pkg::RESP_OK);
    chk("divider", d, scx_pkg::DIV_RST);
    rd(8'h08, scx_pkg::RESP_ERR);
    chk("hole", d, 32'h0);
    rd(scx_pkg::ADDR_TX0, scx_pkg::RESP_ERR);
    wr(scx_pkg::ADDR_RX0, 32'h1, scx_pkg::RESP_ERR);
    wr(scx_pkg::ADDR_CTRL, 32'hff00_0000, scx_pkg::RESP_OK);
    rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
    chk("rsvd", d, 32'h0500_0000);
    wr(scx_pkg::ADDR_DIV, 32'h0005_0004, scx_pkg::RESP_OK);
    xfer(32'h40, 32'ha5, 32'h3c00_0000, 32'ha5, 32'h3c, 32'hff);
    wr(scx_pkg::ADDR_CTRL, 32'h0001_0000, scx_pkg::RESP_OK);
    rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
    chk("flag", {31'h0, d[16]}, 32'h0);
    // 32-bit words, every reorder mode, suspend field 1
    for (i = 0; i < 4; i++) begin
      xfer({11'h0, i[1:0], 3'h0, 4'h1, 12'h0}, 32'h1122_3344, 32'ha1b2_c3d4,
        (i == 1 || i == 2) ? 32'h4433_2211 : 32'h1122_3344,
        (i == 1 || i == 2) ? 32'hd4c3_b2a1 : 32'ha1b2_c3d4, 32'hffff_ffff);
      chk("gap", 32'(maxi), i[0] ? 32'h23 : 32'ha);
    end
    xfer(32'h0010_0040, 32'h5a, 32'h6900_0000, 32'h5a, 32'h69, 32'hff);
    xfer(32'h0010_0080, 32'h1234, 32'habcd_0000, 32'h3412, 32'hcdab, 32'hffff);
    xfer(32'h0080_0080, 32'h1234, 32'habcd_0000, 32'h1234, 32'habcd, 32'hffff);
    chk("clock_pattern", 32'(maxi), 32'hc);
    load1 <= 32'hc300_0000;
    wr(scx_pkg::ADDR_TX1, 32'h5a, scx_pkg::RESP_OK);
    xfer(32'h0040_0040, 32'ha5, 32'h3c00_0000, 32'ha5, 32'h3c, 32'hff);
    chk("lane1", got1 & 32'hff, 32'h5a);
    rd(scx_pkg::ADDR_RX1, scx_pkg::RESP_OK);
    chk("rx1", d & 32'hff, 32'hc3);
    wr(scx_pkg::ADDR_CTRL, 32'h0084_0080, scx_pkg::RESP_OK);
    chk("clk_oe", {31'h0, serial_clock_pin_oe}, 32'h0);
    // fill the transmit buffer, drain it in two four-word bursts
    for (i = 0; i < 8; i++) wr(scx_pkg::ADDR_TX0, 32'h10 + i, scx_pkg::RESP_OK);
    for (i = 0; i < 2; i++) begin
      run(32'h0000_1340);
      chk("burst", got0 & 32'hff, 32'h13 + 4 * i);
      chk("wgap", 32'(maxi), 32'h23);
    end
    wr(scx_pkg::ADDR_TX0, 32'h77, scx_pkg::RESP_OK);
    wr(scx_pkg::ADDR_CTRL, 32'h0000_0001, scx_pkg::RESP_OK);
    wr(scx_pkg::ADDR_CTRL, 32'h0000_0000, scx_pkg::RESP_OK);
    rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
    chk("abort", {31'h0, d[0]}, 32'h0);
    chk("sel_idle", {31'h0, sel_n_o}, 32'h1);
    // slave, byte suspend on 32-bit words, select held over all four bytes
    wr(scx_pkg::ADDR_CTRL, 32'h001d_0000, scx_pkg::RESP_OK);
    wr(scx_pkg::ADDR_CTRL, 32'h001c_0001, scx_pkg::RESP_OK);
    sel_n_i <= 1'b0;
    for (i = 0; i < 64; i++) begin
      repeat (6) @(posedge aclk);
      serial_clock_pin_i <= ~serial_clock_pin_i;
    end
    repeat (6) @(posedge aclk);
    sel_n_i <= 1'b1;
    rd(scx_pkg::ADDR_CTRL, scx_pkg::RESP_OK);
    chk("slv_done", d & 32'h0001_0001, 32'h0001_0000);
    rd(scx_pkg::ADDR_RX0, scx_pkg::RESP_OK);
    chk("slv_rx", d, {32{din0_i}});
    report_and_stop();
  end
endmodule : tb_scx_ctrl
`default_nettype wire
